//--- hw/brbw_pkg.sv
`default_nettype none
package brbw_pkg;

    // word offsets of the configuration registers (byte addresses)
    localparam logic [7:0]  BRBW_OFS_HDR      = 8'h0C;
    localparam logic [7:0]  BRBW_OFS_BUS      = 8'h18;
    localparam logic [7:0]  BRBW_OFS_IOW      = 8'h1C;
    localparam logic [7:0]  BRBW_OFS_IOUP     = 8'h30;

    // field positions inside each word
    localparam int          BRBW_HDR_LSB      = 16;
    localparam int          BRBW_UPBUS_LSB    = 0;
    localparam int          BRBW_DNBUS_LSB    = 8;
    localparam int          BRBW_HIBUS_LSB    = 16;
    localparam int          BRBW_LAT_LSB      = 24;
    localparam int          BRBW_IOB_IND_LSB  = 0;
    localparam int          BRBW_IOB_ADR_LSB  = 4;
    localparam int          BRBW_IOL_IND_LSB  = 8;
    localparam int          BRBW_IOL_ADR_LSB  = 12;
    localparam int          BRBW_IOUP_B_LSB   = 0;
    localparam int          BRBW_IOUP_L_LSB   = 16;

    // fixed and reset values
    localparam logic [7:0]  BRBW_HDR_CODE     = 8'h01;
    localparam logic [7:0]  BRBW_BUS_RST      = 8'h00;
    localparam logic [7:0]  BRBW_LAT_VAL      = 8'h00;
    localparam logic [3:0]  BRBW_IO_IND       = 4'h1;
    localparam logic [3:0]  BRBW_IO_NIB_RST   = 4'h0;
    localparam logic [15:0] BRBW_IO_UP_RST    = 16'h0000;
    localparam logic [11:0] BRBW_IO_BASE_LOW  = 12'h000;
    localparam logic [11:0] BRBW_IO_LIM_LOW   = 12'hFFF;

    // downstream bus range as seen by the forwarding logic
    typedef struct packed {
        logic [7:0] dn;
        logic [7:0] hi;
    } brbw_bus_range_s;

    // assembled 32-bit i/o window bounds
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
    } brbw_io_window_s;

endpackage
`default_nettype wire

//--- hw/brbw_fwd_match.sv
`timescale 1ns/100ps
`default_nettype none
module brbw_fwd_match
    import brbw_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire brbw_io_window_s window,
    input  wire brbw_bus_range_s range,
    input  wire logic            io_req_valid,
    input  wire logic [31:0]     io_req_addr,
    input  wire logic            cfg_req_valid,
    input  wire logic [7:0]      cfg_req_bus,
    output logic                 io_ack_q,
    output logic                 io_claim_q,
    output logic                 cfg_ack_q,
    output logic                 cfg_claim_q
);

    // inclusive range test shared by both decoders
    function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                      input logic [31:0] hi);
        return (lo <= hi) && (v >= lo) && (v <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // i/o window decode, one cycle late so the answer comes from a flop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            io_ack_q   <= 1'b0;
            io_claim_q <= 1'b0;
        end else begin
            io_ack_q   <= io_req_valid;
            io_claim_q <= io_req_valid &&
                          in_range(io_req_addr, window.base, window.limit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration bus-number decode; a reversed range claims nothing
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ack_q   <= 1'b0;
            cfg_claim_q <= 1'b0;
        end else begin
            cfg_ack_q   <= cfg_req_valid;
            cfg_claim_q <= cfg_req_valid &&
                           in_range({24'h000000, cfg_req_bus}, {24'h000000, range.dn},
                                    {24'h000000, range.hi});
        end
    end

endmodule // brbw_fwd_match
`default_nettype wire

//--- hw/brbw_regs.sv
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module brbw_regs
    import brbw_pkg::*;
#(
    parameter int PADDR_W = 12
) (
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               io_req_valid,
    input  wire logic [31:0]        io_req_addr,
    input  wire logic               cfg_req_valid,
    input  wire logic [7:0]         cfg_req_bus,
    output logic                    io_ack,
    output logic                    io_claim,
    output logic                    cfg_ack,
    output logic                    cfg_claim
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check: decode needs at least the low byte of the address
    if (PADDR_W < 8 || PADDR_W > 32) begin : g_bad_width
        $error("brbw_regs: PADDR_W must lie in 8..32");
    end

    logic [7:0]      upbus_q;
    logic [7:0]      dnbus_q;
    logic [7:0]      hibus_q;
    logic [3:0]      iobase_nib_q;
    logic [3:0]      iolim_nib_q;
    logic [15:0]     iobase_up_q;
    logic [15:0]     iolim_up_q;
    logic            pready_q;
    logic [31:0]     prdata_q;
    logic            pslverr_q;
    logic            setup;
    logic            wr_fire;
    brbw_io_window_s window;
    brbw_bus_range_s range;

    ////////////////////////////////////////////////////////////////////////////
    // word decode against a byte offset; the two low address bits are ignored
    function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [7:0] ofs);
        return a[PADDR_W-1:2] == (PADDR_W-2)'(ofs[7:2]);
    endfunction

    function automatic logic mapped(input logic [PADDR_W-1:0] a);
        return hit(a, BRBW_OFS_HDR) || hit(a, BRBW_OFS_BUS) ||
               hit(a, BRBW_OFS_IOW) || hit(a, BRBW_OFS_IOUP);
    endfunction

    // byte-lane merge so narrow writes touch only their own field
    function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input int idx);
        return strb[idx] ? wd[idx*8 +: 8] : old;
    endfunction

    // read word assembly; fields outside this block read as zero
    function automatic logic [31:0] read_word(input logic [PADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        if (hit(a, BRBW_OFS_HDR)) begin
            w[BRBW_HDR_LSB +: 8] = BRBW_HDR_CODE;
        end
        if (hit(a, BRBW_OFS_BUS)) begin
            w[BRBW_UPBUS_LSB +: 8] = upbus_q;
            w[BRBW_DNBUS_LSB +: 8] = dnbus_q;
            w[BRBW_HIBUS_LSB +: 8] = hibus_q;
            w[BRBW_LAT_LSB +: 8]   = BRBW_LAT_VAL;
        end
        if (hit(a, BRBW_OFS_IOW)) begin
            w[BRBW_IOB_IND_LSB +: 4] = BRBW_IO_IND;
            w[BRBW_IOB_ADR_LSB +: 4] = iobase_nib_q;
            w[BRBW_IOL_IND_LSB +: 4] = BRBW_IO_IND;
            w[BRBW_IOL_ADR_LSB +: 4] = iolim_nib_q;
        end
        if (hit(a, BRBW_OFS_IOUP)) begin
            w[BRBW_IOUP_B_LSB +: 16] = iobase_up_q;
            w[BRBW_IOUP_L_LSB +: 16] = iolim_up_q;
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb phases: answer is ready in the first access cycle (no wait states)
    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pready_q && pwrite;

    // read data and error are captured at the setup edge so they leave a flop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q  <= pwrite ? 32'h00000000 : read_word(paddr);
                pslverr_q <= !mapped(paddr);
            end else begin
                prdata_q  <= 32'h00000000;
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus numbers; the latency byte (lane 3) and the header word take no write
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            upbus_q <= BRBW_BUS_RST;
            dnbus_q <= BRBW_BUS_RST;
            hibus_q <= BRBW_BUS_RST;
        end else if (wr_fire && hit(paddr, BRBW_OFS_BUS)) begin
            upbus_q <= lane(upbus_q, pwdata, pstrb, 0);
            dnbus_q <= lane(dnbus_q, pwdata, pstrb, 1);
            hibus_q <= lane(hibus_q, pwdata, pstrb, 2);
        end
    end

    // i/o window nibbles; indicator nibbles are constants and never stored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            iobase_nib_q <= BRBW_IO_NIB_RST;
            iolim_nib_q  <= BRBW_IO_NIB_RST;
        end else if (wr_fire && hit(paddr, BRBW_OFS_IOW)) begin
            if (pstrb[0]) begin
                iobase_nib_q <= pwdata[BRBW_IOB_ADR_LSB +: 4];
            end
            if (pstrb[1]) begin
                iolim_nib_q <= pwdata[BRBW_IOL_ADR_LSB +: 4];
            end
        end
    end

    // upper halves of the window bounds, two lanes each
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            iobase_up_q <= BRBW_IO_UP_RST;
            iolim_up_q  <= BRBW_IO_UP_RST;
        end else if (wr_fire && hit(paddr, BRBW_OFS_IOUP)) begin
            iobase_up_q <= {lane(iobase_up_q[15:8], pwdata, pstrb, 1),
                            lane(iobase_up_q[7:0], pwdata, pstrb, 0)};
            iolim_up_q  <= {lane(iolim_up_q[15:8], pwdata, pstrb, 3),
                            lane(iolim_up_q[7:0], pwdata, pstrb, 2)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // window assembly: low bits are implied, never stored
    assign window.base  = {iobase_up_q, iobase_nib_q, BRBW_IO_BASE_LOW};
    assign window.limit = {iolim_up_q, iolim_nib_q, BRBW_IO_LIM_LOW};
    assign range.dn     = dnbus_q;
    assign range.hi     = hibus_q;

    // forwarding decode; a request sees the registers as they stand at its edge
    brbw_fwd_match u_match (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .window        (window),
        .range         (range),
        .io_req_valid  (io_req_valid),
        .io_req_addr   (io_req_addr),
        .cfg_req_valid (cfg_req_valid),
        .cfg_req_bus   (cfg_req_bus),
        .io_ack_q      (io_ack),
        .io_claim_q    (io_claim),
        .cfg_ack_q     (cfg_ack),
        .cfg_claim_q   (cfg_claim)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_read_setup(logic [7:0] ofs);
        psel && !penable && !pwrite && hit(paddr, ofs);
    endsequence

    sequence s_write_done(logic [7:0] ofs, int ln);
        wr_fire && hit(paddr, ofs) && pstrb[ln];
    endsequence

    // matches a master that idles one cycle between transfers; a master running
    // back to back leaves the checks built on this sequence quiet
    sequence s_write_then_read(logic [7:0] ofs, int ln);
        s_write_done(ofs, ln) ##2 s_read_setup(ofs);
    endsequence

    logic        win_open;
    logic [31:0] lim_plus;
    assign win_open = window.base <= window.limit;
    assign lim_plus = window.limit + 32'h00000001;

    a_apb_answer_timing: assert property (
        setup |=> pready_q ##1 !pready_q)
        else $error("pready not a single cycle after setup");

    a_header_code_read: assert property (
        s_read_setup(BRBW_OFS_HDR) |=> pready_q && prdata_q == 32'h00010000 && !pslverr_q)
        else $error("header word did not read 01h in its byte");

    a_latency_byte_zero: assert property (
        s_read_setup(BRBW_OFS_BUS) |=>
            prdata_q[31:24] == 8'h00 && prdata_q[23:0] == {hibus_q, dnbus_q, upbus_q})
        else $error("bus word read back wrong");

    a_io_indicator_one: assert property (
        s_read_setup(BRBW_OFS_IOW) |=> prdata_q[3:0] == 4'h1 && prdata_q[11:8] == 4'h1
            && prdata_q[31:16] == 16'h0000)
        else $error("i/o indicator nibbles not 1h");

    a_upbus_write: assert property (
        s_write_done(BRBW_OFS_BUS, 0) |=> upbus_q == $past(pwdata[7:0]))
        else $error("upstream bus number not written");

    a_dnbus_write: assert property (
        s_write_done(BRBW_OFS_BUS, 1) |=> dnbus_q == $past(pwdata[15:8]))
        else $error("downstream bus number not written");

    a_hibus_write: assert property (
        s_write_done(BRBW_OFS_BUS, 2) |=> hibus_q == $past(pwdata[23:16]))
        else $error("highest bus number not written");

    a_bus_hold_idle: assert property (
        !(wr_fire && hit(paddr, BRBW_OFS_BUS))
            |=> $stable(upbus_q) && $stable(dnbus_q) && $stable(hibus_q))
        else $error("bus numbers changed without a write");

    a_base_nibble_write: assert property (
        s_write_then_read(BRBW_OFS_IOW, 0) |=> prdata_q[7:4] == $past(pwdata[7:4], 3))
        else $error("base nibble did not read back");

    a_io_base_claim: assert property (
        io_req_valid && io_req_addr == {iobase_up_q, iobase_nib_q, 12'h000} && win_open
            |=> io_ack && io_claim)
        else $error("lowest window address not claimed");

    a_io_limit_claim: assert property (
        io_req_valid && io_req_addr == {iolim_up_q, iolim_nib_q, 12'hFFF} && win_open
            |=> io_ack && io_claim)
        else $error("highest window address not claimed");

    a_io_above_limit: assert property (
        io_req_valid && io_req_addr == lim_plus && lim_plus != 32'h00000000
            |=> io_ack && !io_claim)
        else $error("address above limit was claimed");

    a_io_upper_half: assert property (
        io_req_valid && io_req_addr[31:16] > iolim_up_q |=> !io_claim)
        else $error("upper address half ignored");

    a_io_closed: assert property (
        io_req_valid && !win_open |=> io_ack && !io_claim)
        else $error("closed window claimed a request");

    a_cfg_range_claim: assert property (
        cfg_req_valid && cfg_req_bus == dnbus_q && dnbus_q <= hibus_q |=> cfg_ack && cfg_claim)
        else $error("downstream bus number not claimed");

    a_cfg_above_hi: assert property (
        cfg_req_valid && (cfg_req_bus > hibus_q || cfg_req_bus < dnbus_q)
            |=> cfg_ack && !cfg_claim)
        else $error("bus outside range was claimed");

    a_reset_values: assert property (
        $rose(reset_n) |-> upbus_q == 8'h00 && dnbus_q == 8'h00 && hibus_q == 8'h00
            && iobase_nib_q == 4'h0 && iolim_nib_q == 4'h0)
        else $error("fields not zero after reset");

    // write-then-read checks: what software reads back after a write that strobes the checked lane
    a_limit_nibble_write: assert property (
        s_write_then_read(BRBW_OFS_IOW, 1) |=> prdata_q[15:12] == $past(pwdata[15:12], 3))
        else $error("limit nibble did not read back");

    a_highest_readback: assert property (
        s_write_then_read(BRBW_OFS_BUS, 2) |=> prdata_q[23:16] == $past(pwdata[23:16], 3))
        else $error("highest bus number did not read back");

    a_header_write_ignored: assert property (
        s_write_then_read(BRBW_OFS_HDR, 2) |=> prdata_q[23:16] == 8'h01)
        else $error("header byte changed by a write");

    a_latency_write_ignored: assert property (
        s_write_then_read(BRBW_OFS_BUS, 3) |=> prdata_q[31:24] == 8'h00)
        else $error("latency byte changed by a write");

    a_indicator_write_ignored: assert property (
        s_write_then_read(BRBW_OFS_IOW, 0) |=> prdata_q[3:0] == 4'h1 && prdata_q[11:8] == 4'h1)
        else $error("indicator nibble changed by a write");

    // upper halves and hold checks
    a_upper_base_write: assert property (
        s_write_done(BRBW_OFS_IOUP, 0) |=> iobase_up_q[7:0] == $past(pwdata[7:0]))
        else $error("upper base half not written");

    a_upper_limit_write: assert property (
        s_write_done(BRBW_OFS_IOUP, 3) |=> iolim_up_q[15:8] == $past(pwdata[31:24]))
        else $error("upper limit half not written");

    a_nibble_hold_idle: assert property (
        !(wr_fire && hit(paddr, BRBW_OFS_IOW))
            |=> $stable(iobase_nib_q) && $stable(iolim_nib_q))
        else $error("window nibbles changed without a write");

    a_upper_hold_idle: assert property (
        !(wr_fire && hit(paddr, BRBW_OFS_IOUP))
            |=> $stable(iobase_up_q) && $stable(iolim_up_q))
        else $error("upper halves changed without a write");

    // forwarding edge checks
    a_io_below_base: assert property (
        io_req_valid && io_req_addr < window.base |=> io_ack && !io_claim)
        else $error("address below base was claimed");

    a_cfg_top_claim: assert property (
        cfg_req_valid && cfg_req_bus == hibus_q && dnbus_q <= hibus_q |=> cfg_ack && cfg_claim)
        else $error("highest bus number not claimed");

    a_cfg_reversed: assert property (
        cfg_req_valid && dnbus_q > hibus_q |=> cfg_ack && !cfg_claim)
        else $error("reversed bus range claimed a request");

endmodule // brbw_regs
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import brbw_pkg::*;

    logic        mclk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        io_req_valid;
    logic [31:0] io_req_addr;
    logic        cfg_req_valid;
    logic [7:0]  cfg_req_bus;
    logic        io_ack;
    logic        io_claim;
    logic        cfg_ack;
    logic        cfg_claim;
    int          n_errors;
    int          n_compared;
    int          cycles;
    logic [31:0] io_a [8];
    logic        io_e [8];
    logic [7:0]  cfg_b [8];
    logic        cfg_e [8];

    brbw_regs #(.PADDR_W(12)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
        .cfg_req_valid(cfg_req_valid), .cfg_req_bus(cfg_req_bus), .io_ack(io_ack),
        .io_claim(io_claim), .cfg_ack(cfg_ack), .cfg_claim(cfg_claim)
    );

    // 10 MHz clock
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge; an idle cycle follows
    // so that the next call never reassigns psel in the same time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no local limit: a slave that never answers runs into the hang guard
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic err_exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, s, rd, err);
        check({31'h0, err}, {31'h0, err_exp});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, err_exp});
    endtask

    task automatic put(input int i, input logic [31:0] a, input logic ie,
                       input logic [7:0] b, input logic ce);
        io_a[i]  = a;
        io_e[i]  = ie;
        cfg_b[i] = b;
        cfg_e[i] = ce;
    endtask

    // requests every cycle back to back; answers come two sampling edges later
    task automatic run_fwd(input int n);
        for (int i = 0; i <= n + 2; i++) begin
            @(posedge mclk);
            if (i >= 2 && i <= n + 1) begin
                check({30'h0, io_ack, io_claim}, {30'h0, 1'b1, io_e[i-2]});
                check({30'h0, cfg_ack, cfg_claim}, {30'h0, 1'b1, cfg_e[i-2]});
            end
            if (i == n + 2) begin
                check({30'h0, io_ack, cfg_ack}, 32'h0000_0000);
            end
            if (i < n) begin
                io_req_valid  <= 1'b1;
                io_req_addr   <= io_a[i];
                cfg_req_valid <= 1'b1;
                cfg_req_bus   <= cfg_b[i];
            end else begin
                io_req_valid  <= 1'b0;
                cfg_req_valid <= 1'b0;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        n_errors = 0; n_compared = 0; cycles = 0;
        reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; pstrb = 4'h0; io_req_valid = 1'b0; cfg_req_valid = 1'b0;
        io_req_addr = 32'h0000_0000; cfg_req_bus = 8'h00;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd_chk(12'h00C, 32'h0001_0000, 1'b0);
        rd_chk(12'h018, 32'h0000_0000, 1'b0);
        rd_chk(12'h01C, 32'h0000_0101, 1'b0);
        rd_chk(12'h030, 32'h0000_0000, 1'b0);
        // after reset the window is 0..FFF and the bus range 0..0
        put(0, 32'h0000_0000, 1'b1, 8'h00, 1'b1);
        put(1, 32'h0000_0FFF, 1'b1, 8'h01, 1'b0);
        put(2, 32'h0000_1000, 1'b0, 8'hFF, 1'b0);
        run_fwd(3);
        wr(12'h00C, 32'hFFFF_FFFF, 4'hF, 1'b0);
        rd_chk(12'h00C, 32'h0001_0000, 1'b0);
        wr(12'h018, 32'hFFFF_FFFF, 4'hF, 1'b0);
        rd_chk(12'h018, 32'h00FF_FFFF, 1'b0);
        wr(12'h018, 32'h0000_2000, 4'h2, 1'b0);
        rd_chk(12'h018, 32'h00FF_20FF, 1'b0);
        wr(12'h018, 32'hAB30_0010, 4'hD, 1'b0);
        rd_chk(12'h018, 32'h0030_2010, 1'b0);
        wr(12'h01C, 32'hFFFF_FFFF, 4'hF, 1'b0);
        rd_chk(12'h01C, 32'h0000_F1F1, 1'b0);
        wr(12'h01C, 32'hFFFF_5020, 4'hF, 1'b0);
        rd_chk(12'h01C, 32'h0000_5121, 1'b0);
        wr(12'h030, 32'h0001_0001, 4'hF, 1'b0);
        rd_chk(12'h030, 32'h0001_0001, 1'b0);
        // window 0001_2000..0001_5FFF, buses 20h..30h
        put(0, 32'h0001_1FFF, 1'b0, 8'h1F, 1'b0);
        put(1, 32'h0001_2000, 1'b1, 8'h20, 1'b1);
        put(2, 32'h0001_5FFF, 1'b1, 8'h30, 1'b1);
        put(3, 32'h0001_6000, 1'b0, 8'h31, 1'b0);
        put(4, 32'h0000_3000, 1'b0, 8'h10, 1'b0);
        put(5, 32'h0002_3000, 1'b0, 8'h00, 1'b0);
        run_fwd(6);
        // bounds differing in the upper half, bus range reversed
        wr(12'h01C, 32'h0000_5060, 4'h3, 1'b0);
        wr(12'h030, 32'h0003_0001, 4'hF, 1'b0);
        wr(12'h018, 32'h0020_3010, 4'hF, 1'b0);
        put(0, 32'h0002_0000, 1'b1, 8'h25, 1'b0);
        put(1, 32'h0001_5FFF, 1'b0, 8'h30, 1'b0);
        put(2, 32'h0003_6000, 1'b0, 8'h20, 1'b0);
        put(3, 32'h0003_5FFF, 1'b1, 8'h10, 1'b0);
        run_fwd(4);
        // base above limit closes the window
        wr(12'h030, 32'h0001_0001, 4'hF, 1'b0);
        put(0, 32'h0001_5FFF, 1'b0, 8'h25, 1'b0);
        put(1, 32'h0001_6000, 1'b0, 8'h2F, 1'b0);
        run_fwd(2);
        // unmapped places answer with an error and leave state alone
        rd_chk(12'h040, 32'h0000_0000, 1'b1);
        rd_chk(12'h818, 32'h0000_0000, 1'b1);
        wr(12'h81C, 32'h0000_F0F0, 4'hF, 1'b1);
        rd_chk(12'h01C, 32'h0000_5161, 1'b0);
        // a second reset in mid-run clears every writable field
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd_chk(12'h018, 32'h0000_0000, 1'b0);
        rd_chk(12'h01C, 32'h0000_0101, 1'b0);
        rd_chk(12'h030, 32'h0000_0000, 1'b0);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
